// ---- src/lmw_params.svh ----
`ifndef LMW_PARAMS_SVH
`define LMW_PARAMS_SVH
// filter and timeout figures
`define LMW_CLK_MHZ 125
`define LMW_WAKE_HIGH_US 6
`define LMW_DOM_TIMEOUT_MS 6
`define LMW_TXD_REARM_US 10
`define LMW_BUS_WAKE_CYC 1000
`define LMW_LOCAL_WAKE_CYC 1000
`define LMW_EN_FILT_CYC 500
`define LMW_CNT_W 20
// synchroniser reset: txd and wake idle high, all else low
`define LMW_SYNC_IDLE 7'h18
`endif

// ---- src/lmw_pkg.sv ----
package lmw_pkg;
  typedef enum logic [1:0] {
    MODE_UNPOWERED,
    MODE_FAILSAFE,
    MODE_NORMAL,
    MODE_SLEEP
  } lmw_mode_type;
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_REMOTE,
    SRC_LOCAL
  } lmw_src_type;
endpackage

// ---- src/lmw_filt_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface lmw_filt_if;
  logic raw;
  logic level;
  modport src (output raw, input level);
  modport flt (input raw, output level);
endinterface
`default_nettype wire

// ---- src/lmw_filter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lmw_params.svh"
module lmw_filter #(
  parameter int CYCLES = 16
) (
  input wire logic clk_in,    // clock
  input wire logic rst_in,    // sync reset
  input wire logic init_in,   // reset level
  lmw_filt_if.flt f           // raw in, debounced out
);
  logic [`LMW_CNT_W-1:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d;
  if (CYCLES < 1 || CYCLES >= (1 << `LMW_CNT_W)) begin : g_bad_cycles
    $error("lmw_filter: bad CYCLES");
  end
  // level accepted only after holding CYCLES cycles
  always_comb begin
    lvl_d = lvl_q;
    cnt_d = '0;
    if (f.raw != lvl_q) begin
      if (cnt_q == `LMW_CNT_W'(CYCLES - 1)) begin
        lvl_d = f.raw;
      end else begin
        cnt_d = cnt_q + `LMW_CNT_W'(1);
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lvl_q <= init_in;
      cnt_q <= '0;
    end else begin
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end
  assign f.level = lvl_q;
endmodule
`default_nettype wire

// ---- src/lmw_mode_ctrl.sv ----
// Summary of operation
// - sleep disables transmit and receive paths
// - qualified wake in sleep goes fail-safe
// - fail-safe to normal on enable high
// - separate debounce for wake, bus, enable
// - inhibit off and floating in sleep
// - sleep: termination off unless prewake, weak pull-up only
// - sleep entry ignores bus and wake levels
// - power-up or wake enters fail-safe
// - fail-safe drives inhibit high
// - unpowered to fail-safe above undervoltage
// - fail-safe: driver off, receiver if txd low
// - per-mode outputs per mode table
// - prewake level enables receiver and termination
// - dominant held then rising edge: remote wake
// - remote wake drives receive output low
// - wake pin low held: local wake
// - local wake: rx low, strong txd pull-down
// - rearm local wake after high over 6us
// - txd pin reports wake source in fail-safe
// - enable high clears both wake indications
// - overtemperature disables driver with hysteresis
// - sleep on enable fall with txd high
// - normal: bus follows transmit input
// - dominant timeout releases bus, rearm 10us
`timescale 1ns/1ns
`default_nettype none
`include "lmw_params.svh"
module lmw_mode_ctrl #(
  parameter int BUS_WAKE_CYC = `LMW_BUS_WAKE_CYC,
  parameter int LOCAL_WAKE_CYC = `LMW_LOCAL_WAKE_CYC,
  parameter int EN_FILT_CYC = `LMW_EN_FILT_CYC,
  parameter int DOM_TIMEOUT_CYC = `LMW_DOM_TIMEOUT_MS * 1000 * `LMW_CLK_MHZ
) (
  input wire logic ref_clk_in,          // 125 MHz clock
  input wire logic rst_in,              // sync reset, high
  input wire logic supply_ok_in,        // supply above undervoltage threshold
  input wire logic mode_enable_in,      // host mode enable pin
  input wire logic txd_in,              // transmit pin level
  input wire logic wake_pin_in,         // local wake pin
  input wire logic bus_dominant_in,     // bus at bus_dominant_level
  input wire logic prewake_in,          // bus below prewake_threshold
  input wire logic overtemp_in,         // thermal shutdown with hysteresis
  output logic regulator_inhibit_out,   // inhibit high-side drive
  output logic regulator_inhibit_oe_out, // inhibit driven, else floating
  output logic rxd_out,                 // receive pin level when driven
  output logic rxd_oe_out,              // receive pin driven
  output logic txd_strong_pd_out,       // strong pull-down on transmit pin
  output logic txd_weak_pd_out,         // weak pull-down on transmit pin
  output logic bus_drive_out,           // bus driven dominant
  output logic bus_term_out,            // termination to supply on
  output logic bus_rx_en_out,           // bus receiver enabled
  output logic [1:0] mode_out           // current mode code
);
  localparam int DOM_CYC = (DOM_TIMEOUT_CYC < 1) ? 1 : DOM_TIMEOUT_CYC;
  localparam int WAKE_HIGH_CYC = `LMW_WAKE_HIGH_US * `LMW_CLK_MHZ + 1;
  localparam int REARM_CYC = `LMW_TXD_REARM_US * `LMW_CLK_MHZ + 1;
  localparam int DW = 24;
  if (BUS_WAKE_CYC < 1 || LOCAL_WAKE_CYC < 1 || EN_FILT_CYC < 1) begin : g_bad_filt
    $error("lmw_mode_ctrl: filter counts must be positive");
  end
  if (DOM_CYC >= (1 << DW)) begin : g_bad_dom
    $error("lmw_mode_ctrl: timeout too long");
  end
  if (WAKE_HIGH_CYC >= (1 << DW) || REARM_CYC >= (1 << DW)) begin : g_bad_tmr
    $error("lmw_mode_ctrl: re-arm time too long");
  end

  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  // resets to idle pin levels so no false edge follows reset
  logic [6:0] s1_q, s2_q;
  logic [6:0] pins;
  assign pins = {supply_ok_in, mode_enable_in, txd_in, wake_pin_in,
                 bus_dominant_in, prewake_in, overtemp_in};
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s1_q <= `LMW_SYNC_IDLE;
      s2_q <= `LMW_SYNC_IDLE;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end
  logic sup_s, en_s, txd_s, wake_s, dom_s, pre_s, ot_s;
  assign {sup_s, en_s, txd_s, wake_s, dom_s, pre_s, ot_s} = s2_q;

  // ----------------------------------------------------------
  // debounce filters
  // ----------------------------------------------------------
  lmw_filt_if en_f();
  lmw_filt_if wake_f();
  lmw_filt_if bus_f();
  assign en_f.raw = en_s;
  assign wake_f.raw = wake_s;
  assign bus_f.raw = ~dom_s;
  lmw_filter #(.CYCLES(EN_FILT_CYC)) u_en_filt (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .init_in(1'b0),
    .f(en_f)
  );
  lmw_filter #(.CYCLES(LOCAL_WAKE_CYC)) u_wake_filt (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .init_in(1'b1),
    .f(wake_f)
  );
  lmw_filter #(.CYCLES(BUS_WAKE_CYC)) u_bus_filt (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .init_in(1'b1),
    .f(bus_f)
  );
  logic en_lvl, wake_low, bus_dom_flt;
  assign en_lvl = ~en_f.level;  // high while filtered enable is low
  assign wake_low = ~wake_f.level;
  assign bus_dom_flt = ~bus_f.level;

  // ----------------------------------------------------------
  // mode state and wake flags
  // ----------------------------------------------------------
  lmw_pkg::lmw_mode_type mode_q, mode_d;
  lmw_pkg::lmw_src_type src_q, src_d;
  // edge registers reset to the idle filtered levels
  logic en_prev_q, en_prev_d;
  logic busdom_prev_q, busdom_prev_d;
  logic wlow_prev_q, wlow_prev_d;
  logic wake_armed_q, wake_armed_d;
  logic [DW-1:0] whigh_q, whigh_d;
  logic req_q, req_d;

  always_comb begin
    mode_d = mode_q;
    src_d = src_q;
    req_d = req_q;
    en_prev_d = ~en_lvl;
    busdom_prev_d = bus_dom_flt;
    wlow_prev_d = wake_low;
    wake_armed_d = wake_armed_q;
    whigh_d = whigh_q;
    // wake pin high time for re-arming
    if (wake_s) begin
      if (whigh_q != DW'(WAKE_HIGH_CYC)) begin
        whigh_d = whigh_q + DW'(1);
      end else begin
        wake_armed_d = 1'b1;
      end
    end else begin
      whigh_d = '0;
    end
    if (!sup_s) begin
      mode_d = lmw_pkg::MODE_UNPOWERED;
      src_d = lmw_pkg::SRC_NONE;
      req_d = 1'b0;
    end else begin
      case (mode_q)
        lmw_pkg::MODE_UNPOWERED: begin
          mode_d = lmw_pkg::MODE_FAILSAFE;
        end
        lmw_pkg::MODE_FAILSAFE: begin
          if (~en_lvl) begin
            mode_d = lmw_pkg::MODE_NORMAL;
            src_d = lmw_pkg::SRC_NONE;
            req_d = 1'b0;
          end
        end
        lmw_pkg::MODE_NORMAL: begin
          if (en_lvl && en_prev_q && txd_s) begin
            mode_d = lmw_pkg::MODE_SLEEP;
          end
        end
        lmw_pkg::MODE_SLEEP: begin
          if (busdom_prev_q && !bus_dom_flt) begin
            mode_d = lmw_pkg::MODE_FAILSAFE;
            src_d = lmw_pkg::SRC_REMOTE;
            req_d = 1'b1;
          end else if (wake_low && !wlow_prev_q && wake_armed_q) begin
            mode_d = lmw_pkg::MODE_FAILSAFE;
            src_d = lmw_pkg::SRC_LOCAL;
            req_d = 1'b1;
            wake_armed_d = 1'b0;
          end else if (~en_lvl) begin
            mode_d = lmw_pkg::MODE_FAILSAFE;
          end
        end
        default: mode_d = lmw_pkg::MODE_UNPOWERED;
      endcase
    end
  end

  // ----------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_q <= lmw_pkg::MODE_UNPOWERED;
      src_q <= lmw_pkg::SRC_NONE;
      req_q <= 1'b0;
      en_prev_q <= 1'b0;
      busdom_prev_q <= 1'b0;
      wlow_prev_q <= 1'b0;
      wake_armed_q <= 1'b1;
      whigh_q <= '0;
    end else begin
      mode_q <= mode_d;
      src_q <= src_d;
      req_q <= req_d;
      en_prev_q <= en_prev_d;
      busdom_prev_q <= busdom_prev_d;
      wlow_prev_q <= wlow_prev_d;
      wake_armed_q <= wake_armed_d;
      whigh_q <= whigh_d;
    end
  end

  // ----------------------------------------------------------
  // dominant timeout
  // ----------------------------------------------------------
  logic [DW-1:0] dom_cnt_q, dom_cnt_d;
  logic [DW-1:0] rearm_q, rearm_d;
  logic blocked_q, blocked_d;
  // counters saturate: a stuck txd stays blocked until re-armed
  always_comb begin
    dom_cnt_d = '0;
    rearm_d = '0;
    blocked_d = blocked_q;
    if (!txd_s) begin
      if (dom_cnt_q == DW'(DOM_CYC)) begin
        blocked_d = 1'b1;
        dom_cnt_d = dom_cnt_q;
      end else begin
        dom_cnt_d = dom_cnt_q + DW'(1);
      end
    end else begin
      if (rearm_q == DW'(REARM_CYC)) begin
        blocked_d = 1'b0;
        rearm_d = rearm_q;
      end else begin
        rearm_d = rearm_q + DW'(1);
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      dom_cnt_q <= '0;
      rearm_q <= '0;
      blocked_q <= 1'b0;
    end else begin
      dom_cnt_q <= dom_cnt_d;
      rearm_q <= rearm_d;
      blocked_q <= blocked_d;
    end
  end

  // ----------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------
  logic inh_d, inh_oe_d, rxd_d, rxd_oe_d, spd_d, wpd_d;
  logic drv_d, term_d, rxen_d;
  logic inh_q, inh_oe_q, rxd_q, rxd_oe_q, spd_q, wpd_q;
  logic drv_q, term_q, rxen_q;
  always_comb begin
    inh_d = 1'b0;
    inh_oe_d = 1'b0;
    rxd_d = 1'b1;
    rxd_oe_d = 1'b0;
    spd_d = 1'b0;
    wpd_d = 1'b1;
    drv_d = 1'b0;
    term_d = 1'b0;
    rxen_d = 1'b0;
    case (mode_d)
      lmw_pkg::MODE_FAILSAFE: begin
        inh_d = 1'b1;
        inh_oe_d = 1'b1;
        term_d = 1'b1;
        rxen_d = !txd_s;
        rxd_oe_d = req_d;
        rxd_d = !req_d;
        spd_d = (src_d == lmw_pkg::SRC_LOCAL);
        wpd_d = (src_d != lmw_pkg::SRC_LOCAL);
      end
      lmw_pkg::MODE_NORMAL: begin
        inh_d = 1'b1;
        inh_oe_d = 1'b1;
        term_d = 1'b1;
        rxen_d = 1'b1;
        rxd_oe_d = dom_s;  // open drain pulls low only
        rxd_d = !dom_s;
        drv_d = !txd_s && !blocked_d && !ot_s;
      end
      lmw_pkg::MODE_SLEEP: begin
        term_d = pre_s;
        rxen_d = pre_s;
        // inhibit floating, rxd high ohmic
      end
      default: begin
        wpd_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------
  // output registers
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      inh_q <= 1'b0;
      inh_oe_q <= 1'b0;
      rxd_q <= 1'b1;
      rxd_oe_q <= 1'b0;
      spd_q <= 1'b0;
      wpd_q <= 1'b0;
      drv_q <= 1'b0;
      term_q <= 1'b0;
      rxen_q <= 1'b0;
    end else begin
      inh_q <= inh_d;
      inh_oe_q <= inh_oe_d;
      rxd_q <= rxd_d;
      rxd_oe_q <= rxd_oe_d;
      spd_q <= spd_d;
      wpd_q <= wpd_d;
      drv_q <= drv_d;
      term_q <= term_d;
      rxen_q <= rxen_d;
    end
  end
  assign regulator_inhibit_out = inh_q;
  assign regulator_inhibit_oe_out = inh_oe_q;
  assign rxd_out = rxd_q;
  assign rxd_oe_out = rxd_oe_q;
  assign txd_strong_pd_out = spd_q;
  assign txd_weak_pd_out = wpd_q;
  assign bus_drive_out = drv_q;
  assign bus_term_out = term_q;
  assign bus_rx_en_out = rxen_q;
  assign mode_out = mode_q;
endmodule
`default_nettype wire

// ---- verif/lmw_mode_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module lmw_mode_monitor (
  input wire logic ref_clk_in,               // clock
  input wire logic rst_in,                   // reset
  input wire logic supply_ok_in,             // supply
  input wire logic mode_enable_in,           // enable
  input wire logic txd_in,                   // txd
  input wire logic wake_pin_in,              // wake
  input wire logic bus_dominant_in,          // bus
  input wire logic prewake_in,               // prewake
  input wire logic overtemp_in,              // hot
  input wire logic regulator_inhibit_out,    // inhibit
  input wire logic regulator_inhibit_oe_out, // inhibit oe
  input wire logic rxd_out,                  // rxd
  input wire logic rxd_oe_out,               // rxd oe
  input wire logic txd_strong_pd_out,        // strong pd
  input wire logic txd_weak_pd_out,          // weak pd
  input wire logic bus_drive_out,            // drive
  input wire logic bus_term_out,             // term
  input wire logic bus_rx_en_out,            // rx en
  input wire logic [1:0] mode_out            // mode
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ----------
  // mode checks
  // ----------
  a_sleep_inh_off: assert property (mode_out == 2'h3 && $past(mode_out) == 2'h3
    |-> !regulator_inhibit_oe_out) else $error("inhibit driven in sleep");
  a_sleep_path_off: assert property (mode_out == 2'h3 && $past(mode_out) == 2'h3
    |-> !bus_drive_out && !rxd_oe_out) else $error("path active in sleep");
  a_fs_inh_on: assert property (mode_out == 2'h1 && $past(mode_out) == 2'h1
    |-> regulator_inhibit_out && regulator_inhibit_oe_out) else $error("inhibit off");
  a_sleep_term_off: assert property ($past(mode_out) == 2'h2 ##0
    (mode_out == 2'h3 && !prewake_in)[*4] |-> !bus_term_out) else $error("term on");
  a_wake_to_fs: assert property ($past(mode_out) == 2'h3 && mode_out != 2'h3
    |-> mode_out == 2'h1) else $error("sleep left not to failsafe");
  a_normal_from_fs: assert property ($changed(mode_out) && mode_out == 2'h2
    |-> $past(mode_out) == 2'h1) else $error("normal not from failsafe");
  a_txd_low_stay: assert property ((mode_out == 2'h2 && !txd_in)[*8]
    |=> mode_out == 2'h2) else $error("sleep with txd low");
  a_txd_high_rel: assert property ((mode_out == 2'h2 && txd_in)[*4]
    |-> !bus_drive_out) else $error("bus driven with txd high");
  a_hot_drive_off: assert property (overtemp_in[*4] |-> !bus_drive_out)
    else $error("bus driven when hot");
  a_src_one_pd: assert property (txd_strong_pd_out |-> !txd_weak_pd_out)
    else $error("both pull-downs on");
  c_sleep: cover property ($past(mode_out) == 2'h2 && mode_out == 2'h3);
  c_normal: cover property ($past(mode_out) == 2'h1 && mode_out == 2'h2);
  c_local: cover property (mode_out == 2'h1 && txd_strong_pd_out);
endmodule
bind lmw_mode_ctrl lmw_mode_monitor lmw_mode_monitor_i (.ref_clk_in, .rst_in, .supply_ok_in,
  .mode_enable_in, .txd_in, .wake_pin_in, .bus_dominant_in, .prewake_in, .overtemp_in,
  .regulator_inhibit_out, .regulator_inhibit_oe_out, .rxd_out, .rxd_oe_out,
  .txd_strong_pd_out, .txd_weak_pd_out, .bus_drive_out, .bus_term_out, .bus_rx_en_out,
  .mode_out);
`default_nettype wire

// ---- verif/lmw_far_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module lmw_far_model (
  input wire logic host_txd_in,  // host txd level
  input wire logic host_oe_in,   // host drives txd
  input wire logic node_dom_in,  // other node pulls bus
  input wire logic drive_in,     // transceiver pulls bus
  input wire logic strong_pd_in, // strong txd pull-down
  input wire logic rxd_in,       // rxd value
  input wire logic rxd_oe_in,    // rxd driven
  output logic txd_out,          // txd pin
  output logic bus_dom_out,      // bus dominant
  output logic prewake_out,      // bus below prewake
  output logic rxd_pin_out       // rxd pin
);
  // released txd sits at host pull-up unless strongly pulled
  assign txd_out = host_oe_in ? host_txd_in : !strong_pd_in;
  assign bus_dom_out = drive_in | node_dom_in;
  assign prewake_out = bus_dom_out;
  assign rxd_pin_out = rxd_oe_in ? rxd_in : 1'b1;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic supply_ok_in = 1'b0;
  logic mode_enable_in = 1'b0;
  logic wake_pin_in = 1'b1;
  logic overtemp_in = 1'b0;
  logic host_txd_in = 1'b1;
  logic host_oe_in = 1'b1;
  logic node_dom_in = 1'b0;
  wire logic txd_in, bus_dominant_in, prewake_in, rxd_pin;
  logic regulator_inhibit_out, regulator_inhibit_oe_out, rxd_out, rxd_oe_out;
  logic txd_strong_pd_out, txd_weak_pd_out, bus_drive_out, bus_term_out, bus_rx_en_out;
  logic [1:0] mode_out;
  int err_total = 0;
  int compares = 0;
  int exp_mode = 0;
  int exp_src = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  lmw_mode_ctrl #(.BUS_WAKE_CYC(4), .LOCAL_WAKE_CYC(4), .EN_FILT_CYC(4), .DOM_TIMEOUT_CYC(50))
    lmw_mode_ctrl_i (.ref_clk_in, .rst_in, .supply_ok_in, .mode_enable_in, .txd_in,
    .wake_pin_in, .bus_dominant_in, .prewake_in, .overtemp_in, .regulator_inhibit_out,
    .regulator_inhibit_oe_out, .rxd_out, .rxd_oe_out, .txd_strong_pd_out, .txd_weak_pd_out,
    .bus_drive_out, .bus_term_out, .bus_rx_en_out, .mode_out);
  lmw_far_model lmw_far_model_i (.host_txd_in, .host_oe_in, .node_dom_in,
    .drive_in(bus_drive_out), .strong_pd_in(txd_strong_pd_out), .rxd_in(rxd_out),
    .rxd_oe_in(rxd_oe_out), .txd_out(txd_in), .bus_dom_out(bus_dominant_in),
    .prewake_out(prewake_in), .rxd_pin_out(rxd_pin));
  // ----------
  // helpers
  // ----------
  task automatic conclude;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // waits for the mode, then checks every output but bus_rx_en_out against the model
  task automatic wait_mode(input int m);
    int k;
    logic on;
    k = 0;
    exp_mode = m;
    while (mode_out !== m[1:0] && k < 200) begin
      cyc(1);
      k++;
    end
    cyc(2);
    on = (m == 1 || m == 2);
    chk(mode_out, exp_mode[1:0]);
    chk({regulator_inhibit_out, regulator_inhibit_oe_out}, {on, on});
    chk({bus_drive_out, txd_strong_pd_out}, {1'b0, exp_src == 2});
    chk({bus_term_out, txd_weak_pd_out}, {on, exp_src != 2 && m != 0});
    if (m == 3) begin
      chk({rxd_oe_out, bus_term_out}, 2'h0);
    end else begin
      chk({rxd_pin, regulator_inhibit_oe_out}, {exp_src == 0, on});
    end
  endtask
  // ----------
  // tests
  // ----------
  initial begin
    void'($urandom(11));
    cyc(6);
    rst_in = 1'b0;
    cyc(5);
    chk(mode_out, 2'h0);
    supply_ok_in = 1'b1;
    wait_mode(1);
    host_txd_in = 1'b0;
    cyc(5);
    chk({bus_rx_en_out, bus_drive_out}, 2'h2);
    host_txd_in = 1'b1;
    $display("test power_up done");
    mode_enable_in = 1'b1;
    wait_mode(2);
    for (int i = 0; i < 20; i++) begin
      host_txd_in = 1'($urandom);
      cyc(8);
      chk({bus_drive_out, rxd_pin}, {!host_txd_in, host_txd_in});
      host_txd_in = 1'b1;
      cyc(2);
    end
    host_txd_in = 1'b0;
    cyc(60);
    chk({bus_drive_out, 1'b1}, 2'h1);
    host_txd_in = 1'b1;
    cyc(300);
    host_txd_in = 1'b0;
    cyc(6);
    chk({bus_drive_out, 1'b1}, 2'h1);
    host_txd_in = 1'b1;
    cyc(1260);
    host_txd_in = 1'b0;
    cyc(6);
    chk({bus_drive_out, overtemp_in}, 2'h2);
    overtemp_in = 1'b1;
    cyc(6);
    chk({bus_drive_out, overtemp_in}, 2'h1);
    overtemp_in = 1'b0;
    cyc(6);
    chk({bus_drive_out, overtemp_in}, 2'h2);
    host_txd_in = 1'b1;
    $display("test normal done");
    cyc(4);
    mode_enable_in = 1'b0;
    wait_mode(3);
    node_dom_in = 1'b1;
    cyc(2);
    node_dom_in = 1'b0;
    cyc(20);
    chk(mode_out, 2'h3);
    node_dom_in = 1'b1;
    cyc(10);
    chk({bus_rx_en_out, bus_term_out}, 2'h3);
    chk(mode_out, 2'h3);
    node_dom_in = 1'b0;
    host_oe_in = 1'b0;
    exp_src = 1;
    wait_mode(1);
    chk({txd_in, txd_weak_pd_out}, 2'h3);
    host_oe_in = 1'b1;
    exp_src = 0;
    mode_enable_in = 1'b1;
    wait_mode(2);
    $display("test remote done");
    mode_enable_in = 1'b0;
    wait_mode(3);
    wake_pin_in = 1'b0;
    cyc(2);
    wake_pin_in = 1'b1;
    cyc(800);
    chk(mode_out, 2'h3);
    wake_pin_in = 1'b0;
    host_oe_in = 1'b0;
    exp_src = 2;
    wait_mode(1);
    chk({txd_in, txd_strong_pd_out}, 2'h1);
    host_oe_in = 1'b1;
    exp_src = 0;
    mode_enable_in = 1'b1;
    wait_mode(2);
    mode_enable_in = 1'b0;
    wait_mode(3);
    cyc(40);
    chk(mode_out, 2'h3);
    wake_pin_in = 1'b1;
    cyc(300);
    wake_pin_in = 1'b0;
    cyc(40);
    chk(mode_out, 2'h3);
    wake_pin_in = 1'b1;
    cyc(800);
    wake_pin_in = 1'b0;
    exp_src = 2;
    host_oe_in = 1'b0;
    wait_mode(1);
    $display("test local done");
    host_oe_in = 1'b1;
    exp_src = 0;
    supply_ok_in = 1'b0;
    wait_mode(0);
    supply_ok_in = 1'b1;
    wait_mode(1);
    mode_enable_in = 1'b1;
    wait_mode(2);
    mode_enable_in = 1'b0;
    wait_mode(3);
    mode_enable_in = 1'b1;
    wait_mode(2);
    $display("test supply done");
    conclude;
  end
  initial begin
    #(8 * 20000);
    err_total++;
    conclude;
  end
endmodule
`default_nettype wire
